// >>> core/omc_pkg.sv
// Shared constants, types and register layout of the operating mode controller.
package omc_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [7:0] CTRL_OFFSET     = 8'h00;
   localparam logic [7:0] STATUS_OFFSET   = 8'h04;

   // Field positions in the control register.
   localparam int         CTRL_STOP_EN_BIT  = 0;
   localparam int         CTRL_DEBUG_EN_BIT = 1;
   localparam int         CTRL_LVD_EN_BIT   = 2;
   localparam int         CTRL_LVS_EN_BIT   = 3;
   localparam int         CTRL_PPD_SEL_BIT  = 4;
   localparam int         CTRL_PPD_ACK_BIT  = 5;

   // Field positions in the status register.
   localparam int         STAT_MODE_LSB     = 0;
   localparam int         STAT_PARTIAL_POWERDOWN_FLAG_BIT     = 8;
   localparam int         STAT_REG_BIT      = 9;
   localparam int         STAT_DBGCLK_BIT   = 10;

   // Value of the control fields after reset.
   localparam logic [4:0] CTRL_RESET_VALUE  = 5'h00;

   // Address of the vector fetched on leaving reset into run mode.
   localparam logic [15:0] RESET_VECTOR     = 16'hFFFE;

   // Control fields carried together.
   typedef struct packed {
      logic ppd_select;
      logic lv_stop_en;
      logic lv_detect_en;
      logic debug_en;
      logic stop_en;
   } omc_ctrl_type;

   // Operating modes, one-hot.
   typedef enum logic [5:0] {
      MODE_RESET = 6'h01,
      MODE_RUN   = 6'h02,
      MODE_BG    = 6'h04,
      MODE_WAIT  = 6'h08,
      MODE_STOP3 = 6'h10,
      MODE_STOP2 = 6'h20
   } omc_mode_type;

   // Serial debug command classes as presented by the debug controller.
   typedef enum logic [2:0] {
      CMD_MEM        = 3'h0,
      CMD_MEM_STATUS = 3'h1,
      CMD_DBG_REG    = 3'h2,
      CMD_BACKGROUND = 3'h3,
      CMD_CPU_REG    = 3'h4,
      CMD_TRACE      = 3'h5,
      CMD_GO         = 3'h6
   } omc_cmd_type;

endpackage

// >>> core/omc_core.sv
// Operating mode controller: reset mode select, wait, stop3 and stop2 sequencing.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module omc_core #(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest,
   // Pins
   input  wire logic          reset_pin_n,
   input  wire logic          mode_select_debug_pin,
   // CPU events
   input  wire logic          wait_exec,
   input  wire logic          stop_exec,
   input  wire logic          background_halt_instruction,
   input  wire logic          breakpoint_match,
   input  wire logic          debug_force_reset,
   // Interrupt sources
   input  wire logic          irq_any,
   input  wire logic          irq_lvd,
   input  wire logic          irq_adc,
   input  wire logic          irq_sci,
   input  wire logic          irq_pin,
   // Debug command port from the background debug controller
   input  wire logic          dbg_cmd_valid,
   input  wire logic [2:0]    dbg_cmd,
   output logic               dbg_cmd_done,
   output logic               dbg_cmd_err,
   output logic               dbg_cmd_refused,
   // CPU control
   output logic               cpu_clk_en,
   output logic               cpu_suspend,
   output logic               cpu_fetch_reset_vector,
   output logic [15:0]        reset_vector,
   output logic               cpu_take_irq,
   output logic               clear_imask,
   output logic               illegal_opcode_reset,
   // System control
   output logic               bus_clk_en,
   output logic               debug_clk_en,
   output logic               regulator_full,
   output logic               adc_stop_run,
   output logic               ref_clk_keep_allowed,
   output logic               state_retain,
   output logic               io_latch_hold,
   output logic               partial_powerdown_flag,
   output logic [5:0]         mode
);

   // An address narrower than three bits cannot reach the status register.
   if (ADDR_W < 3) begin : g_addr_check
      $error("ADDR_W must be at least 3");
   end

   omc_pkg::omc_mode_type mode_ff, nxt_mode;
   omc_pkg::omc_ctrl_type ctrl_ff, nxt_ctrl;
   logic                  por_ff, nxt_por;
   logic                  partial_powerdown_flag_ff, nxt_partial_powerdown_flag;
   logic                  s3_dbg_ff, s3_reg_ff, s3_adc_ff;
   logic                  ack_ff;
   logic [31:0]           rdata_ff;
   logic                  vec_ff, nxt_vec;
   logic                  irqv_ff, nxt_irqv;
   logic                  imask_ff, nxt_imask;
   logic                  illegal_ff, nxt_illegal;
   logic                  done_ff, err_ff, refused_ff;

   // Bus decode.
   wire        bus_req    = avs_read | avs_write;
   wire [7:0]  addr_byte  = 8'(avs_address);
   wire        hit_ctrl   = addr_byte == omc_pkg::CTRL_OFFSET;
   wire        hit_status = addr_byte == omc_pkg::STATUS_OFFSET;
   wire        wr_take    = avs_write & ack_ff & avs_byteenable[0] & hit_ctrl;
   wire        ppd_ack    = wr_take & avs_writedata[omc_pkg::CTRL_PPD_ACK_BIT];

   // Stop selection, sampled at the STOP instruction.
   wire        lv_stop    = ctrl_ff.lv_detect_en & ctrl_ff.lv_stop_en;
   wire        sel_stop2  = ~ctrl_ff.debug_en & ~lv_stop & ctrl_ff.ppd_select;

   // Debug command classes.
   wire        is_bgcmd   = dbg_cmd == omc_pkg::CMD_BACKGROUND;
   wire        is_mstat   = dbg_cmd == omc_pkg::CMD_MEM_STATUS;
   wire        is_go      = dbg_cmd == omc_pkg::CMD_GO;
   wire        non_intr   = dbg_cmd <= omc_pkg::CMD_BACKGROUND;
   wire        active_cmd = dbg_cmd >= omc_pkg::CMD_CPU_REG && dbg_cmd <= omc_pkg::CMD_GO;
   wire        in_low     = mode_ff == omc_pkg::MODE_WAIT
                          || (mode_ff == omc_pkg::MODE_STOP3 && s3_dbg_ff);
   wire        cmd_ok     = (mode_ff == omc_pkg::MODE_RUN && non_intr)
                          || (mode_ff == omc_pkg::MODE_BG && (non_intr || active_cmd))
                          || (in_low && (is_bgcmd || is_mstat));
   wire        cmd_take   = dbg_cmd_valid & cmd_ok;
   wire        cmd_err    = cmd_take & is_mstat & in_low;
   wire        bg_cmd     = cmd_take & is_bgcmd;
   wire        s3_wake    = irq_lvd | irq_adc | irq_sci | irq_pin;
   wire        ms_bg      = por_ff & ~mode_select_debug_pin;

   always_comb begin
      nxt_mode    = mode_ff;
      nxt_por     = por_ff;
      nxt_vec     = 1'b0;
      nxt_irqv    = 1'b0;
      nxt_imask   = 1'b0;
      nxt_illegal = 1'b0;
      nxt_partial_powerdown_flag    = partial_powerdown_flag_ff & ~ppd_ack;
      nxt_ctrl    = ctrl_ff;
      if (wr_take) begin
         nxt_ctrl = omc_pkg::omc_ctrl_type'(avs_writedata[4:0]);
      end
      if (debug_force_reset) begin
         nxt_mode = omc_pkg::MODE_RESET;
         nxt_por  = 1'b1;
      end else if (!reset_pin_n) begin
         nxt_mode = omc_pkg::MODE_RESET;
         nxt_por  = 1'b0;
         if (mode_ff == omc_pkg::MODE_STOP2) begin
            // Wake from stop2 behaves as power-on; it sets the flag and resets the control fields.
            nxt_por  = 1'b1;
            nxt_partial_powerdown_flag = 1'b1;
            nxt_ctrl = omc_pkg::omc_ctrl_type'(omc_pkg::CTRL_RESET_VALUE);
         end
      end else begin
         unique case (mode_ff)
            omc_pkg::MODE_RESET: begin
               if (ms_bg) begin
                  nxt_mode = omc_pkg::MODE_BG;
               end else begin
                  nxt_mode = omc_pkg::MODE_RUN;
                  nxt_vec  = 1'b1;
               end
               nxt_por = 1'b0;
            end
            omc_pkg::MODE_RUN: begin
               if (bg_cmd || background_halt_instruction || breakpoint_match) begin
                  nxt_mode = omc_pkg::MODE_BG;
               end else if (stop_exec) begin
                  if (!ctrl_ff.stop_en) begin
                     nxt_mode    = omc_pkg::MODE_RESET;
                     nxt_illegal = 1'b1;
                  end else if (sel_stop2) begin
                     nxt_mode = omc_pkg::MODE_STOP2;
                  end else begin
                     nxt_mode = omc_pkg::MODE_STOP3;
                  end
               end else if (wait_exec) begin
                  nxt_mode  = omc_pkg::MODE_WAIT;
                  nxt_imask = 1'b1;
               end
            end
            omc_pkg::MODE_BG: begin
               if (cmd_take && is_go) begin
                  nxt_mode = omc_pkg::MODE_RUN;
               end
            end
            omc_pkg::MODE_WAIT: begin
               if (bg_cmd) begin
                  nxt_mode = omc_pkg::MODE_BG;
               end else if (irq_any) begin
                  nxt_mode = omc_pkg::MODE_RUN;
                  nxt_irqv = 1'b1;
               end
            end
            omc_pkg::MODE_STOP3: begin
               if (s3_wake) begin
                  nxt_mode = omc_pkg::MODE_RUN;
                  nxt_irqv = 1'b1;
               end else if (bg_cmd) begin
                  nxt_mode = omc_pkg::MODE_BG;
               end
            end
            omc_pkg::MODE_STOP2: begin
               nxt_mode = omc_pkg::MODE_STOP2;
            end
            default: begin
               nxt_mode = omc_pkg::MODE_RESET;
            end
         endcase
      end
   end

   // Mode and control state.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_ff <= omc_pkg::MODE_RESET;
         por_ff  <= 1'b1;
         partial_powerdown_flag_ff <= 1'b0;
         ctrl_ff <= omc_pkg::omc_ctrl_type'(omc_pkg::CTRL_RESET_VALUE);
      end else begin
         mode_ff <= nxt_mode;
         por_ff  <= nxt_por;
         partial_powerdown_flag_ff <= nxt_partial_powerdown_flag;
         ctrl_ff <= nxt_ctrl;
      end
   end

   // Stop3 attributes are frozen at entry so later writes cannot disturb them.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s3_dbg_ff <= 1'b0;
         s3_reg_ff <= 1'b0;
         s3_adc_ff <= 1'b0;
      end else if (mode_ff == omc_pkg::MODE_RUN && nxt_mode == omc_pkg::MODE_STOP3) begin
         s3_dbg_ff <= ctrl_ff.debug_en;
         s3_reg_ff <= ctrl_ff.debug_en | lv_stop;
         s3_adc_ff <= lv_stop;
      end
   end

   // Event pulses, registered.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         vec_ff     <= 1'b0;
         irqv_ff    <= 1'b0;
         imask_ff   <= 1'b0;
         illegal_ff <= 1'b0;
         done_ff    <= 1'b0;
         err_ff     <= 1'b0;
         refused_ff <= 1'b0;
      end else begin
         vec_ff     <= nxt_vec;
         irqv_ff    <= nxt_irqv;
         imask_ff   <= nxt_imask;
         illegal_ff <= nxt_illegal;
         done_ff    <= cmd_take & ~cmd_err;
         err_ff     <= cmd_err;
         refused_ff <= dbg_cmd_valid & ~cmd_ok;
      end
   end

   // One wait state per access keeps read data registered.
   wire [31:0] status_word = {21'h000000, debug_clk_en, regulator_full, partial_powerdown_flag_ff,
                              2'h0, mode_ff};
   wire [31:0] rdata_sel   = hit_ctrl   ? {27'h0000000, ctrl_ff} :
                             hit_status ? status_word : 32'h00000000;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ack_ff   <= bus_req & ~ack_ff;
         rdata_ff <= rdata_sel;
      end
   end

   assign avs_waitrequest        = bus_req & ~ack_ff;
   assign avs_readdata           = rdata_ff;

   // Mode decoding onto clock and power controls.
   wire in_stop3 = mode_ff == omc_pkg::MODE_STOP3;
   wire in_stop  = in_stop3 || mode_ff == omc_pkg::MODE_STOP2;
   assign cpu_clk_en             = mode_ff == omc_pkg::MODE_RUN
                                || mode_ff == omc_pkg::MODE_BG;
   assign cpu_suspend            = mode_ff != omc_pkg::MODE_RUN;
   assign bus_clk_en             = ~in_stop & (mode_ff != omc_pkg::MODE_RESET);
   assign debug_clk_en           = ~in_stop | (in_stop3 & s3_dbg_ff);
   assign regulator_full         = ~in_stop | (in_stop3 & s3_reg_ff);
   assign adc_stop_run           = in_stop3 & s3_adc_ff;
   assign ref_clk_keep_allowed   = in_stop3;
   assign state_retain           = in_stop3;
   assign io_latch_hold          = (mode_ff == omc_pkg::MODE_STOP2) | partial_powerdown_flag_ff;
   assign partial_powerdown_flag = partial_powerdown_flag_ff;
   assign mode                   = mode_ff;
   assign cpu_fetch_reset_vector = vec_ff;
   assign reset_vector           = omc_pkg::RESET_VECTOR;
   assign cpu_take_irq           = irqv_ff;
   assign clear_imask            = imask_ff;
   assign illegal_opcode_reset   = illegal_ff;
   assign dbg_cmd_done           = done_ff;
   assign dbg_cmd_err            = err_ff;
   assign dbg_cmd_refused        = refused_ff;

   // Checks.
   wire calm = reset_pin_n & ~debug_force_reset;

   reset_run_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_RESET && calm && !ms_bg
      |=> mode_ff == omc_pkg::MODE_RUN && vec_ff && reset_vector == 16'hFFFE)
      else $error("reset exit did not enter run with vector fetch");

   reset_bg_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_RESET && calm && por_ff && !mode_select_debug_pin
      |=> mode_ff == omc_pkg::MODE_BG && !vec_ff)
      else $error("mode pin low did not give background mode");

   halt_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_RUN && calm && (background_halt_instruction || breakpoint_match)
      |=> mode_ff == omc_pkg::MODE_BG ##0 cpu_suspend)
      else $error("halt event did not enter background mode");

   bg_suspend_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_BG |-> cpu_suspend && !vec_ff)
      else $error("CPU not suspended in background mode");

   wait_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_RUN && calm && wait_exec && !stop_exec && !dbg_cmd_valid
      && !background_halt_instruction && !breakpoint_match
      |=> clear_imask && !cpu_clk_en && bus_clk_en && regulator_full)
      else $error("wait entry wrong");

   wait_status_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_WAIT && dbg_cmd_valid && is_mstat
      |=> dbg_cmd_err && !dbg_cmd_done && !dbg_cmd_refused)
      else $error("status command in wait not reported as error");

   active_only_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff != omc_pkg::MODE_BG && dbg_cmd_valid && active_cmd
      |=> dbg_cmd_refused && !dbg_cmd_done)
      else $error("active command accepted outside background mode");

   stop_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_RUN && calm && stop_exec && !ctrl_ff.stop_en && !dbg_cmd_valid
      && !background_halt_instruction && !breakpoint_match
      |=> illegal_opcode_reset && mode_ff == omc_pkg::MODE_RESET)
      else $error("disabled stop did not force illegal-opcode reset");

   stop_guard_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_RUN && calm && stop_exec && !dbg_cmd_valid
      && !background_halt_instruction && !breakpoint_match
      && ctrl_ff.stop_en && (ctrl_ff.debug_en || lv_stop)
      |=> mode_ff == omc_pkg::MODE_STOP3 && regulator_full && !bus_clk_en)
      else $error("guarded stop did not yield stop3 with regulator on");

   partial_powerdown_flag_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      partial_powerdown_flag_ff && !ppd_ack |=> partial_powerdown_flag_ff ##0 io_latch_hold)
      else $error("partial-powerdown flag dropped without acknowledge");

   stop3_wake_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_STOP3 && calm && s3_wake
      |=> mode_ff == omc_pkg::MODE_RUN && cpu_take_irq)
      else $error("interrupt did not end stop3");

   stop2_wake_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_STOP2 && !reset_pin_n && !debug_force_reset
      |=> mode_ff == omc_pkg::MODE_RESET && partial_powerdown_flag_ff && por_ff)
      else $error("stop2 wake did not restart as power-on");

   wake_cov: cover property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_WAIT ##1 mode_ff == omc_pkg::MODE_RUN && cpu_take_irq);
   stop3_bg_cov: cover property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_STOP3 ##1 mode_ff == omc_pkg::MODE_BG);
   stop2_wake_cov: cover property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_STOP2 ##1 mode_ff == omc_pkg::MODE_RESET ##1 partial_powerdown_flag_ff);
   go_cov: cover property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_BG ##1 mode_ff == omc_pkg::MODE_RUN);
   stop3_reg_cov: cover property (@(posedge clk_sys) disable iff (rst)
      mode_ff == omc_pkg::MODE_STOP3 && regulator_full && !debug_clk_en);

endmodule // omc_core

// >>> verif/omc_far_model.sv
// Behavioural model of the CPU, the interrupt sources and the debug host.
`timescale 1ns/1ps
module omc_far_model (
   // Clock
   input  wire logic       clk_sys,
   // CPU events and interrupt levels, packed
   output logic [9:0]      strobe,
   // Debug host
   output logic            dbg_cmd_valid,
   output logic [2:0]      dbg_cmd,
   output logic            mode_select_debug_pin
);
   initial begin
      strobe = 10'h000;
      dbg_cmd_valid = 1'b0;
      dbg_cmd = 3'h0;
      mode_select_debug_pin = 1'b1;
   end
   task automatic pulse(input logic [9:0] m);
      @(posedge clk_sys);
      strobe <= m;
      @(posedge clk_sys);
      strobe <= 10'h000;
   endtask
   // The host holds the pin low around a reset to ask for background entry.
   task automatic set_pin(input logic v);
      @(posedge clk_sys);
      mode_select_debug_pin <= v;
   endtask
   // The class lines are inverted after the strobe so no stale value can pass.
   task automatic cmd(input logic [2:0] c);
      @(posedge clk_sys);
      dbg_cmd_valid <= 1'b1;
      dbg_cmd <= c;
      @(posedge clk_sys);
      dbg_cmd_valid <= 1'b0;
      dbg_cmd <= ~c;
   endtask
endmodule // omc_far_model

// >>> verif/tb_operating_mode_controller.sv
// Self-checking bench for the operating mode controller.
`timescale 1ns/1ps
module tb_operating_mode_controller;
   localparam logic [2:0] DONE = 3'h4;
   localparam logic [2:0] ERR  = 3'h2;
   localparam logic [2:0] REF  = 3'h1;
   localparam logic [9:0] WAKE [4] = '{10'h040, 10'h080, 10'h100, 10'h200};
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        reset_pin_n = 1'b1;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [9:0]  strobe;
   logic [2:0]  dbg_cmd;
   logic [15:0] reset_vector;
   logic [5:0]  mode;
   logic [4:0]  c;
   logic        avs_waitrequest, mode_select_debug_pin, dbg_cmd_valid, dbg_cmd_done, dbg_cmd_err;
   logic        dbg_cmd_refused, cpu_clk_en, cpu_suspend, cpu_fetch_reset_vector, cpu_take_irq;
   logic        clear_imask, illegal_opcode_reset, bus_clk_en, debug_clk_en, regulator_full;
   logic        adc_stop_run, ref_clk_keep_allowed, state_retain, io_latch_hold;
   logic        partial_powerdown_flag;
   int          num_errors = 0;
   int          checks_done = 0;
   always #2.5 clk_sys = ~clk_sys;
   omc_far_model far_u (.clk_sys, .strobe, .dbg_cmd_valid, .dbg_cmd, .mode_select_debug_pin);
   omc_core dut_u (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .reset_pin_n,
      .mode_select_debug_pin, .wait_exec(strobe[0]), .stop_exec(strobe[1]),
      .background_halt_instruction(strobe[2]), .breakpoint_match(strobe[3]),
      .debug_force_reset(strobe[4]), .irq_any(strobe[5]), .irq_lvd(strobe[6]),
      .irq_adc(strobe[7]), .irq_sci(strobe[8]), .irq_pin(strobe[9]), .dbg_cmd_valid, .dbg_cmd,
      .dbg_cmd_done, .dbg_cmd_err, .dbg_cmd_refused, .cpu_clk_en, .cpu_suspend,
      .cpu_fetch_reset_vector, .reset_vector, .cpu_take_irq, .clear_imask, .illegal_opcode_reset,
      .bus_clk_en, .debug_clk_en, .regulator_full, .adc_stop_run, .ref_clk_keep_allowed,
      .state_retain, .io_latch_hold, .partial_powerdown_flag, .mode);
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   // Stop selection in fixed priority: disabled, debug, low voltage, powerdown select.
   function automatic logic [5:0] exp_mode(input logic [4:0] v);
      if (!v[0]) return omc_pkg::MODE_RESET;
      if (v[1] || (v[2] && v[3]) || !v[4]) return omc_pkg::MODE_STOP3;
      return omc_pkg::MODE_STOP2;
   endfunction
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         $display("Error at %0t: got %h expected %h", $time, avs_waitrequest, 1'b0);
         num_errors++;
         give_verdict();
      end
   endtask
   task automatic dc(input logic [2:0] cm, input logic [2:0] e);
      far_u.cmd(cm);
      #1;
      chk({dbg_cmd_done, dbg_cmd_err, dbg_cmd_refused}, e);
   endtask
   task automatic pin_reset;
      @(posedge clk_sys);
      reset_pin_n <= 1'b0;
      @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      #1;
      chk(mode, omc_pkg::MODE_RESET);
      @(posedge clk_sys);
      #1;
      chk({mode, cpu_fetch_reset_vector}, {omc_pkg::MODE_RUN, 1'b1});
   endtask
   initial begin
      q = $urandom(32'h8721);
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({mode, cpu_fetch_reset_vector, reset_vector}, {omc_pkg::MODE_RUN, 17'h1FFFE});
      bus(1'b0, omc_pkg::STATUS_OFFSET[3:0], 32'h0, q);
      chk(q[5:0], omc_pkg::MODE_RUN);
      bus(1'b1, 4'h8, 32'hFF, q);
      bus(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h0);
      // A control write without byte lane 0 must leave the control fields alone.
      avs_byteenable <= 4'hE;
      bus(1'b1, omc_pkg::CTRL_OFFSET[3:0], 32'h1F, q);
      avs_byteenable <= 4'hF;
      bus(1'b0, omc_pkg::CTRL_OFFSET[3:0], 32'h0, q);
      chk(q, 32'h0);
      for (int k = 0; k < 8; k++) begin
         if (k != 3) dc(k[2:0], (k < 3) ? DONE : REF);
      end
      dc(3'h3, DONE);
      chk({mode, cpu_suspend, cpu_clk_en}, {omc_pkg::MODE_BG, 2'b11});
      for (int k = 0; k < 7; k++) dc(k[2:0], DONE);
      chk(mode, omc_pkg::MODE_RUN);
      far_u.pulse(10'h001);
      #1;
      chk({mode, clear_imask, cpu_clk_en, bus_clk_en, regulator_full},
          {omc_pkg::MODE_WAIT, 4'hB});
      dc(3'h1, ERR);
      dc(3'h0, REF);
      far_u.pulse(10'h020);
      #1;
      chk({mode, cpu_take_irq}, {omc_pkg::MODE_RUN, 1'b1});
      far_u.pulse(10'h001);
      dc(3'h3, DONE);
      chk(mode, omc_pkg::MODE_BG);
      for (int k = 2; k < 4; k++) begin
         dc(3'h6, DONE);
         far_u.pulse((k == 2) ? 10'h004 : 10'h008);
         #1;
         chk(mode, omc_pkg::MODE_BG);
      end
      dc(3'h6, DONE);
      // Every selection combination first, then random ones.
      for (int i = 0; i < 40; i++) begin
         c = (i < 32) ? i[4:0] : 5'($urandom);
         bus(1'b1, omc_pkg::CTRL_OFFSET[3:0], {27'h0, c}, q);
         far_u.pulse(10'h002);
         #1;
         chk({mode, illegal_opcode_reset}, {exp_mode(c), !c[0]});
         if (!c[0]) begin
            @(posedge clk_sys);
            #1;
            chk(mode, omc_pkg::MODE_RUN);
         end else if (exp_mode(c) == omc_pkg::MODE_STOP3) begin
            chk({bus_clk_en, cpu_clk_en, state_retain, ref_clk_keep_allowed, regulator_full,
                 debug_clk_en, adc_stop_run}, {4'h3, c[1] | (c[2] & c[3]), c[1], c[2] & c[3]});
            dc(3'h1, c[1] ? ERR : REF);
            if ($urandom_range(0, 4) == 0) begin
               pin_reset();
            end else begin
               far_u.pulse(WAKE[$urandom_range(0, 3)]);
               #1;
               chk({mode, cpu_take_irq}, {omc_pkg::MODE_RUN, 1'b1});
            end
         end else begin
            chk({bus_clk_en, cpu_clk_en, io_latch_hold}, 3'h1);
            pin_reset();
            chk({partial_powerdown_flag, io_latch_hold}, 2'h3);
            bus(1'b1, omc_pkg::CTRL_OFFSET[3:0], 32'h20, q);
            #1;
            chk({partial_powerdown_flag, io_latch_hold}, 2'h0);
         end
      end
      far_u.set_pin(1'b0);
      far_u.pulse(10'h010);
      @(posedge clk_sys);
      #1;
      chk(mode, omc_pkg::MODE_BG);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(mode, omc_pkg::MODE_BG);
      give_verdict();
   end
endmodule // tb_operating_mode_controller
